// *** hdl/plc_cell.sv ***
// Added by the designer: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps

module plc_cell #(
  parameter int CLUSTER = 0,
  parameter int SLOT = 0,
  parameter int ROW_CLUSTERS = 8,
  parameter int TBUS_W = 4
) (
  // System
  input wire logic clk,
  input wire logic reset,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Cell data and chains
  input wire plc_pkg::plc_din_t din,
  input wire logic carry_in,
  input wire logic cascade_in,
  output logic carry_out,
  output logic cascade_out,
  // Cluster controls
  input wire logic cluster_clk_a,
  input wire logic cluster_clk_b,
  input wire logic cluster_ctrl_a_n,
  input wire logic cluster_ctrl_b_n,
  input wire logic chip_reset_n,
  // Cell outputs
  output logic out_local,
  output logic out_row,
  // Emulated internal bus
  input wire logic [TBUS_W-1:0] tbus_data,
  input wire logic [TBUS_W-1:0] tbus_oe,
  output logic tbus
);

  // ****************************************
  // Elaboration checks and chain position
  // ****************************************
  localparam int CPC = plc_pkg::CELLS_PER_CLUSTER;

  initial begin
    if (SLOT < 0 || SLOT >= CPC || ROW_CLUSTERS < 2 ||
        ROW_CLUSTERS % 2 != 0 || CLUSTER < 0 ||
        CLUSTER >= ROW_CLUSTERS || TBUS_W < 1) begin
      $error("plc_cell: illegal geometry parameters");
    end
  end

  // First slot of a cluster is fed by cluster CLUSTER-2, same parity
  localparam bit NO_FEED = (SLOT == 0) &&
    (CLUSTER < plc_pkg::CLUSTER_SKIP);
  // Memory block sits at the row centre, so no chain crosses it
  localparam bit CENTRE = (SLOT == 0) &&
    ((CLUSTER == ROW_CLUSTERS / 2) ||
     (CLUSTER == ROW_CLUSTERS / 2 + 1));

  // ****************************************
  // Register bus
  // ****************************************
  plc_pkg::plc_ctrl_t ctrl;
  logic [15:0] lut_mask;
  logic [plc_pkg::STAT_W-1:0] status;
  logic take;

  assign take = !avs_waitrequest;

  // One wait cycle: answer stands for exactly one edge
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl <= plc_pkg::plc_ctrl_t'(plc_pkg::CTRL_RST);
    end else if (take && avs_write &&
                 avs_address[3:2] == plc_pkg::CTRL_OFS[3:2]) begin
      ctrl <= plc_pkg::plc_ctrl_t'(avs_writedata[16:0]);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lut_mask <= plc_pkg::LUT_RST;
    end else if (take && avs_write &&
                 avs_address[3:2] == plc_pkg::LUT_OFS[3:2]) begin
      lut_mask <= avs_writedata[15:0];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && avs_waitrequest) begin
      unique case (avs_address[3:2])
        plc_pkg::CTRL_OFS[3:2]: avs_readdata <= {15'h0000, ctrl};
        plc_pkg::LUT_OFS[3:2]: avs_readdata <= {16'h0000, lut_mask};
        plc_pkg::STAT_OFS[3:2]: avs_readdata <= {27'h0000000, status};
        default: avs_readdata <= 32'h00000000;
      endcase
    end
  end

  // ****************************************
  // Clear, preset and load decode
  // ****************************************
  logic bad_cp, inv, ld_en, ld_act, ld_val, a_act, b_act, clr_by;
  logic chip_act, force_zero, force_one;

  assign bad_cp = ctrl.cp > plc_pkg::CP_LD;
  assign a_act = !cluster_ctrl_a_n;
  assign b_act = !cluster_ctrl_b_n;
  assign chip_act = ctrl.chip_rst_en && !chip_reset_n;

  // Controls a mode does not use are ignored, as if tied high
  always_comb begin
    inv = 1'b0;
    ld_en = 1'b0;
    clr_by = 1'b0;
    unique case (ctrl.cp)
      plc_pkg::CP_PRE: begin
        inv = ctrl.pre_inv;
        ld_en = !ctrl.pre_inv;
        clr_by = ctrl.pre_inv && a_act;
      end
      plc_pkg::CP_CLR_PRE: begin
        ld_en = 1'b1;
        clr_by = b_act;
      end
      plc_pkg::CP_LD_CLR: begin
        ld_en = 1'b1;
        clr_by = b_act;
      end
      plc_pkg::CP_LD_PRE: begin
        inv = 1'b1;
        ld_en = 1'b1;
        clr_by = b_act;
      end
      plc_pkg::CP_LD: ld_en = 1'b1;
      default: clr_by = a_act || b_act;
    endcase
  end

  // Load drives clear or preset by the value on input c
  assign ld_act = ld_en && a_act;
  assign ld_val = din.cell_input_c ^ inv;
  assign force_zero = chip_act || clr_by ||
    (ld_act && !ld_val);
  assign force_one = ld_act && ld_val;

  // ****************************************
  // Lookup tables
  // ****************************************
  logic lut4_y, t1, t2, t_q;
  logic [3:0] lut4_sel;
  logic [2:0] t_sel;
  logic c_or_carry;

  assign c_or_carry = ctrl.c_is_carry ? carry_in
    : din.cell_input_c;
  assign lut4_sel = {din.cell_input_d, c_or_carry,
    din.cell_input_b, din.cell_input_a};
  assign t_sel = (ctrl.mode == plc_pkg::MODE_ARITH)
    ? {carry_in, din.cell_input_b, din.cell_input_a}
    : {din.cell_input_b, carry_in, t_q};

  plc_lut #(.N(plc_pkg::LUT_INPUTS)) u_lut4 (
    .mask(lut_mask),
    .sel(lut4_sel),
    .y(lut4_y)
  );

  plc_lut #(.N(plc_pkg::TABLE_INPUTS)) u_tsum (
    .mask(lut_mask[7:0]),
    .sel(t_sel),
    .y(t1)
  );

  plc_lut #(.N(plc_pkg::TABLE_INPUTS)) u_tcarry (
    .mask(lut_mask[15:8]),
    .sel(t_sel),
    .y(t2)
  );

  // ****************************************
  // Cascade and carry
  // ****************************************
  logic casc_in_eff, table_val, casc_val;

  // A chain head sees the identity of the merge operator
  assign casc_in_eff = (ctrl.chain_start || NO_FEED || CENTRE)
    ? !ctrl.casc_or : cascade_in;
  assign table_val = (ctrl.mode == plc_pkg::MODE_NORMAL)
    ? lut4_y : t1;
  // OR form is AND with both sides and the result inverted
  assign casc_val = ctrl.casc_or
    ? !(!table_val && !casc_in_eff)
    : (table_val && casc_in_eff);
  assign cascade_out = casc_val;
  assign carry_out = (ctrl.mode == plc_pkg::MODE_NORMAL)
    ? 1'b0 : t2;

  // ****************************************
  // Register next value
  // ****************************************
  logic base, next_q, ena, sel_clk, clk_prev, tick, load_sel;
  logic stored;

  assign t_q = stored ^ inv;
  assign load_sel = din.cell_input_d;

  // Counters use carry-in as count enable, so bit 0 needs it high
  always_comb begin
    base = t_q;
    unique case (ctrl.mode)
      plc_pkg::MODE_NORMAL: base = ctrl.pack
        ? din.cell_input_d : lut4_y;
      plc_pkg::MODE_ARITH: base = t1;
      plc_pkg::MODE_UPDOWN: base = load_sel ? din.cell_input_c
        : (carry_in ? t1 : t_q);
      plc_pkg::MODE_CLRCNT: base = (load_sel ? din.cell_input_c
        : (carry_in ? t1 : t_q)) && cascade_in;
    endcase
  end

  // Input b serves as K or R for two-input storage types
  always_comb begin
    next_q = base;
    unique case (ctrl.ff_type)
      plc_pkg::FF_D: next_q = base;
      plc_pkg::FF_T: next_q = t_q ^ base;
      plc_pkg::FF_JK: next_q = (base && !t_q) ||
        (!din.cell_input_b && t_q);
      plc_pkg::FF_SR: next_q = base ||
        (!din.cell_input_b && t_q);
    endcase
  end

  assign ena = ctrl.ena_from_a ? din.cell_input_a : 1'b1;
  assign sel_clk = ctrl.clk_sel ? cluster_clk_b : cluster_clk_a;
  assign tick = sel_clk && !clk_prev;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      clk_prev <= 1'b1;
    end else begin
      clk_prev <= sel_clk;
    end
  end

  // Packed or not, the same controls reach the storage bit
  plc_store u_store (
    .clk(clk),
    .reset(reset),
    .force_zero(force_zero),
    .force_one(force_one),
    .capture(tick && ena),
    .d(next_q ^ inv),
    .q(stored)
  );

  // ****************************************
  // Outputs and status
  // ****************************************
  assign out_local = ctrl.local_reg ? t_q : casc_val;
  assign out_row = ctrl.row_reg ? t_q : casc_val;
  assign status = {bad_cp, casc_val, carry_out, table_val, t_q};

  // Contention pulls low, an idle bus floats high
  logic [$clog2(TBUS_W+1)-1:0] n_on;
  logic sel_bit;

  always_comb begin
    n_on = '0;
    sel_bit = 1'b1;
    for (int i = 0; i < TBUS_W; i++) begin
      if (tbus_oe[i]) begin
        n_on = n_on + 1'b1;
        sel_bit = tbus_data[i];
      end
    end
  end

  assign tbus = (n_on == '0) ? 1'b1
    : ((n_on == 1'b1) ? sel_bit : 1'b0);

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  logic quiet;
  assign quiet = !force_zero && !force_one;

  sequence s_capture;
    quiet && tick && ena && $stable(ctrl);
  endsequence

  sequence s_held_load;
    (ld_act && !clr_by && !chip_act && $stable(ld_val))[*2];
  endsequence

  capture_edge_a: assert property (
    s_capture ##1 quiet |-> t_q == $past(next_q))
    else $error("register missed its clock edge");
  no_tick_hold_a: assert property (
    quiet && !(tick && ena) ##1 quiet && $stable(inv) |-> $stable(t_q))
    else $error("register changed without enabled edge");
  async_load_a: assert property (
    s_held_load |-> t_q == din.cell_input_c)
    else $error("asynchronous load failed");
  clear_only_a: assert property (
    (ctrl.cp == plc_pkg::CP_CLR && (a_act || b_act))[*2] |-> !t_q)
    else $error("clear-only did not clear");
  chip_reset_a: assert property (
    (chip_act && $stable(inv))[*2] |-> t_q == inv)
    else $error("chip reset not dominant");
  sync_clear_a: assert property (
    ctrl.mode == plc_pkg::MODE_CLRCNT && !cascade_in |-> !base)
    else $error("synchronous clear ignored");
  arith_carry_a: assert property (
    ctrl.mode == plc_pkg::MODE_ARITH |->
      carry_out == lut_mask[8 + t_sel])
    else $error("carry table wrong");
  cascade_merge_a: assert property (
    ctrl.mode == plc_pkg::MODE_NORMAL && !ctrl.casc_or && !casc_in_eff
      |-> !cascade_out)
    else $error("cascade AND not applied");
  tbus_resolve_a: assert property (
    (tbus_oe == '0 |-> tbus) and ($countones(tbus_oe) > 1 |-> !tbus))
    else $error("emulated bus resolved wrongly");
  bus_answer_a: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest
      ##1 avs_waitrequest)
    else $error("bus answer not one cycle");

endmodule : plc_cell

// *** hdl/plc_lut.sv ***
`timescale 1ns/1ps

module plc_lut #(
  parameter int N = 4
) (
  // Table contents and select
  input wire logic [(1<<N)-1:0] mask,
  input wire logic [N-1:0] sel,
  // Result
  output logic y
);

  initial begin
    if (N < 1 || N > 6) begin
      $error("plc_lut: N out of range");
    end
  end

  // Any function of N variables is one bit of the mask
  assign y = mask[sel];

endmodule : plc_lut

// *** hdl/plc_store.sv ***
`timescale 1ns/1ps

module plc_store (
  // Clock and resets
  input wire logic clk,
  input wire logic reset,
  // Asynchronous controls, active high here
  input wire logic force_zero,
  input wire logic force_one,
  // Synchronous path
  input wire logic capture,
  input wire logic d,
  // Stored bit
  output logic q
);

  // Zero beats one so chip reset and clear dominate preset
  always_ff @(posedge clk or posedge reset or posedge force_zero
              or posedge force_one) begin
    if (reset) begin
      q <= 1'b0;
    end else if (force_zero) begin
      q <= 1'b0;
    end else if (force_one) begin
      q <= 1'b1;
    end else if (capture) begin
      q <= d;
    end
  end

endmodule : plc_store

// *** shared/plc_pkg.sv ***
package plc_pkg;

  // ****************************************
  // Cluster geometry
  // ****************************************
  localparam int CELLS_PER_CLUSTER = 8;
  localparam int CLUSTER_SKIP = 2;
  localparam int LUT_INPUTS = 4;
  localparam int TABLE_INPUTS = 3;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] LUT_OFS = 4'h4;
  localparam logic [3:0] STAT_OFS = 4'h8;
  localparam logic [16:0] CTRL_RST = 17'h00000;
  localparam logic [15:0] LUT_RST = 16'h0000;
  localparam int STAT_Q = 0;
  localparam int STAT_LUT = 1;
  localparam int STAT_CARRY = 2;
  localparam int STAT_CASC = 3;
  localparam int STAT_BAD = 4;
  localparam int STAT_W = 5;

  // ****************************************
  // Modes and carriers
  // ****************************************
  typedef enum logic [1:0] {
    MODE_NORMAL, MODE_ARITH, MODE_UPDOWN, MODE_CLRCNT
  } plc_mode_t;

  typedef enum logic [2:0] {
    CP_CLR, CP_PRE, CP_CLR_PRE, CP_LD_CLR, CP_LD_PRE, CP_LD
  } plc_cp_t;

  typedef enum logic [1:0] {FF_D, FF_T, FF_JK, FF_SR} plc_ff_t;

  typedef struct packed {
    logic chain_start;
    logic pre_inv;
    logic chip_rst_en;
    logic ena_from_a;
    logic pack;
    logic row_reg;
    logic local_reg;
    logic c_is_carry;
    logic casc_or;
    logic clk_sel;
    plc_ff_t ff_type;
    plc_cp_t cp;
    plc_mode_t mode;
  } plc_ctrl_t;

  typedef struct packed {
    logic cell_input_d;
    logic cell_input_c;
    logic cell_input_b;
    logic cell_input_a;
  } plc_din_t;

endpackage : plc_pkg

// *** testbench/plc_nbr.sv ***
`timescale 1ns/1ps

// Far side of the cell: the upstream neighbour and the cluster lines
module plc_nbr (
  // System
  input wire logic clk,
  input wire logic reset,
  // Requests from the bench
  input wire logic go,
  input wire logic use_b,
  input wire logic up_val,
  input wire logic up_carry,
  input wire logic hold_a,
  input wire logic hold_b,
  // Lines into the cell
  output logic cluster_clk_a,
  output logic cluster_clk_b,
  output logic cascade_in,
  output logic carry_in,
  output logic cluster_ctrl_a_n,
  output logic cluster_ctrl_b_n
);
  // Cluster clocks stand low between single-cycle pulses
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cluster_clk_a <= 1'b0;
      cluster_clk_b <= 1'b0;
    end else begin
      cluster_clk_a <= go & ~use_b;
      cluster_clk_b <= go & use_b;
    end
  end
  // Upstream cell hands its merged result and carry straight on
  assign cascade_in = up_val;
  assign carry_in = up_carry;
  // Active low; an idle line rests high so it never acts
  assign cluster_ctrl_a_n = ~hold_a;
  assign cluster_ctrl_b_n = ~hold_b;
endmodule : plc_nbr

// *** testbench/tb_programmable_logic_cell.sv ***
`timescale 1ns/1ps

module tb_programmable_logic_cell;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  plc_pkg::plc_din_t din = '0;
  logic go = 1'b0, use_b = 1'b0, up_val = 1'b1, up_carry = 1'b0;
  logic hold_a = 1'b0, hold_b = 1'b0, chip_reset_n = 1'b1;
  logic clk_a, clk_b, casc_in, car_in, ctl_a_n, ctl_b_n;
  logic carry_out, cascade_out, out_local, out_row, tbus;
  logic [3:0] tbus_data = 4'ha, tbus_oe = 4'h0;
  plc_pkg::plc_ctrl_t cw;
  int n_errors = 0, checks_done = 0, cycles = 0;

  always #50 clk = ~clk;

  plc_nbr i_nbr (.clk(clk), .reset(reset), .go(go), .use_b(use_b),
    .up_val(up_val), .up_carry(up_carry), .hold_a(hold_a),
    .hold_b(hold_b), .cluster_clk_a(clk_a), .cluster_clk_b(clk_b),
    .cascade_in(casc_in), .carry_in(car_in),
    .cluster_ctrl_a_n(ctl_a_n), .cluster_ctrl_b_n(ctl_b_n));

  // Slot 1 of cluster 2 keeps the cell off every chain head
  plc_cell #(.CLUSTER(2), .SLOT(1)) i_dut (.clk(clk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .din(din), .carry_in(car_in), .cascade_in(casc_in),
    .carry_out(carry_out), .cascade_out(cascade_out),
    .cluster_clk_a(clk_a), .cluster_clk_b(clk_b),
    .cluster_ctrl_a_n(ctl_a_n), .cluster_ctrl_b_n(ctl_b_n),
    .chip_reset_n(chip_reset_n), .out_local(out_local),
    .out_row(out_row), .tbus_data(tbus_data), .tbus_oe(tbus_oe),
    .tbus(tbus));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic wrap_up;
    if (n_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      $display("FAIL %s expected %h seen %h", what, exp, seen);
      n_errors++;
    end
  endtask : check

  // Request held until waitrequest is sampled low; no latency assumed
  task automatic bus(logic wr, logic [3:0] a, logic [31:0] wd,
      output logic [31:0] rd);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= ~wr;
    // Only the bench timeout ends a wait that never completes
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic wr(logic [3:0] a, logic [31:0] d);
    logic [31:0] rd;
    bus(1'b1, a, d, rd);
  endtask : wr

  task automatic rd_chk(string what, logic [3:0] a, logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, a, 32'h0, rd);
    check(what, rd, exp);
  endtask : rd_chk

  // One single-cycle pulse on cluster clock a or b, then settle
  task automatic pulse(logic b);
    @(posedge clk);
    go <= 1'b1;
    use_b <= b;
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : pulse

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs;
    rd_chk("ctrl", plc_pkg::CTRL_OFS, {15'h0, plc_pkg::CTRL_RST});
    rd_chk("lut", plc_pkg::LUT_OFS, {16'h0, plc_pkg::LUT_RST});
    rd_chk("stat", plc_pkg::STAT_OFS, 32'h0);
    wr(4'hc, 32'hffffffff);
    rd_chk("unmapped", 4'hc, 32'h0);
    wr(plc_pkg::STAT_OFS, 32'hffffffff);
    rd_chk("stat ro", plc_pkg::STAT_OFS, 32'h0);
    wr(plc_pkg::LUT_OFS, 32'hffff6b2d);
    rd_chk("lut rw", plc_pkg::LUT_OFS, 32'h00006b2d);
  endtask : t_regs

  task automatic t_normal;
    logic t, e;
    for (int k = 0; k < 4; k++) begin
      cw = '0;
      cw.casc_or = k[0];
      cw.c_is_carry = k[1];
      wr(plc_pkg::CTRL_OFS, {15'h0, cw});
      for (int i = 0; i < 32; i++) begin
        @(posedge clk);
        din <= i[3:0] ^ {1'b0, k[1], 2'b0};
        up_carry <= i[2] ^ ~k[1];
        up_val <= i[4];
        @(negedge clk);
        t = 16'h6b2d >> i[3:0];
        e = k[0] ? (t | i[4]) : (t & i[4]);
        check("cascade", cascade_out, e);
        check("local", out_local, e);
        check("row", out_row, e);
      end
    end
  endtask : t_normal

  task automatic t_arith;
    cw = '0;
    cw.mode = plc_pkg::MODE_ARITH;
    wr(plc_pkg::CTRL_OFS, {15'h0, cw});
    wr(plc_pkg::LUT_OFS, 32'h0000e896);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      din <= {2'b0, i[1:0]};
      up_carry <= i[2];
      up_val <= i[3];
      @(negedge clk);
      check("sum", cascade_out, (^i[2:0]) & i[3]);
      check("carry", carry_out, (i[2:0] > 2) && i[2:0] != 4);
    end
  endtask : t_arith

  task automatic t_pack;
    cw = '0;
    cw.pack = 1'b1;
    cw.local_reg = 1'b1;
    cw.ena_from_a = 1'b1;
    wr(plc_pkg::CTRL_OFS, {15'h0, cw});
    wr(plc_pkg::LUT_OFS, 32'h0000f0f0);
    up_val <= 1'b1;
    din <= 4'b1000;
    pulse(1'b0);
    check("ena off", out_local, 1'b0);
    check("packed row", out_row, 1'b0);
    @(posedge clk);
    din <= 4'b1101;
    pulse(1'b1);
    check("other clk", out_local, 1'b0);
    pulse(1'b0);
    check("capture", out_local, 1'b1);
    check("packed row", out_row, 1'b1);
    cw.clk_sel = 1'b1;
    wr(plc_pkg::CTRL_OFS, {15'h0, cw});
    din <= 4'b0001;
    pulse(1'b1);
    check("clk b", out_local, 1'b0);
  endtask : t_pack

  task automatic t_async;
    plc_pkg::plc_cp_t cps[11] = '{plc_pkg::CP_CLR, plc_pkg::CP_CLR,
      plc_pkg::CP_CLR_PRE, plc_pkg::CP_CLR_PRE, plc_pkg::CP_LD_CLR,
      plc_pkg::CP_LD_CLR, plc_pkg::CP_LD, plc_pkg::CP_LD_PRE,
      plc_pkg::CP_LD_PRE, plc_pkg::CP_PRE, plc_pkg::CP_PRE};
    // Per case: line b, first stored value, input c, expected value
    logic [3:0] cs[11] = '{4'b0100, 4'b1100, 4'b1100, 4'b0011, 4'b0100,
      4'b1110, 4'b0011, 4'b1001, 4'b0100, 4'b0011, 4'b0001};
    cw = '0;
    cw.pack = 1'b1;
    cw.local_reg = 1'b1;
    for (int i = 0; i < 11; i++) begin
      cw.cp = cps[i];
      cw.pre_inv = (i == 10);
      wr(plc_pkg::CTRL_OFS, {15'h0, cw});
      din <= {cs[i][2], 3'b001};
      pulse(1'b0);
      // Data settles an edge before the line acts, so no load race
      @(posedge clk);
      din <= {cs[i][2], cs[i][1], 2'b01};
      @(posedge clk);
      hold_a <= ~cs[i][3];
      hold_b <= cs[i][3];
      @(negedge clk);
      check("async", out_local, cs[i][0]);
      @(posedge clk);
      hold_a <= 1'b0;
      hold_b <= 1'b0;
    end
    cw.cp = plc_pkg::CP_CLR;
    cw.chip_rst_en = 1'b1;
    wr(plc_pkg::CTRL_OFS, {15'h0, cw});
    din <= 4'b1001;
    pulse(1'b0);
    @(posedge clk);
    chip_reset_n <= 1'b0;
    pulse(1'b0);
    check("chip reset", out_local, 1'b0);
    @(posedge clk);
    chip_reset_n <= 1'b1;
    cw.cp = plc_pkg::CP_LD_PRE;
    wr(plc_pkg::CTRL_OFS, {15'h0, cw});
    chip_reset_n <= 1'b0;
    @(negedge clk);
    check("chip preset", out_local, 1'b1);
    @(posedge clk);
    chip_reset_n <= 1'b1;
  endtask : t_async

  task automatic t_ff;
    // Per step: storage type, input d, input b, expected value
    logic [4:0] fs[7] = '{5'b01101, 5'b01100, 5'b10101, 5'b10110,
      5'b11101, 5'b11001, 5'b11010};
    cw = '0;
    cw.pack = 1'b1;
    cw.local_reg = 1'b1;
    wr(plc_pkg::CTRL_OFS, {15'h0, cw});
    hold_a <= 1'b1;
    @(posedge clk);
    hold_a <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      cw.ff_type = plc_pkg::plc_ff_t'(fs[i][4:3]);
      wr(plc_pkg::CTRL_OFS, {15'h0, cw});
      din <= {fs[i][2], 1'b0, fs[i][1], 1'b0};
      pulse(1'b0);
      check("storage", out_local, fs[i][0]);
    end
  endtask : t_ff

  task automatic t_count;
    // Per step: clearable, load select, load data, enable, sync clear_n, q
    logic [5:0] st[6] = '{6'b011101, 6'b001100, 6'b000101, 6'b000001,
      6'b111100, 6'b111111};
    cw = '0;
    cw.mode = plc_pkg::MODE_UPDOWN;
    cw.local_reg = 1'b1;
    wr(plc_pkg::CTRL_OFS, {15'h0, cw});
    wr(plc_pkg::LUT_OFS, 32'h00000066);
    for (int i = 0; i < 6; i++) begin
      if (i == 4) begin
        cw.mode = plc_pkg::MODE_CLRCNT;
        wr(plc_pkg::CTRL_OFS, {15'h0, cw});
      end
      @(posedge clk);
      din <= {st[i][4:3], 2'b00};
      up_carry <= st[i][2];
      up_val <= st[i][1];
      pulse(1'b0);
      check("counter", out_local, st[i][0]);
    end
  endtask : t_count

  task automatic t_tbus;
    for (int i = 0; i < 32; i++) begin
      @(posedge clk);
      tbus_oe <= i[3:0];
      tbus_data <= i[4] ? 4'h5 : 4'ha;
      @(negedge clk);
      check("tbus", tbus, (i[3:0] == 0) ? 1'b1 : ($onehot(i[3:0]) ?
        |(i[3:0] & (i[4] ? 4'h5 : 4'ha)) : 1'b0));
    end
  endtask : t_tbus

  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_normal();
    t_arith();
    t_pack();
    t_async();
    t_count();
    t_ff();
    t_tbus();
    wrap_up();
  end
endmodule : tb_programmable_logic_cell
